// ===== sim/tpf_link_partner.sv
// Link-side model that takes each pause frame after a chosen number of cycles.
`timescale 1ns/10ps
module tpf_link_partner (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       frame_req_i,
  input  wire logic [1:0] dly_i,
  output logic            frame_ack_o
);
  logic [1:0] wait_q;
  // The ack is a single pulse; a request still held after it is counted again and acknowledged again.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !frame_req_i || frame_ack_o) begin
      wait_q      <= 2'h0;
      frame_ack_o <= 1'b0;
    end else if (wait_q == dly_i) begin
      frame_ack_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : tpf_link_partner

// ===== sim/tx_pause_flow_control_tb.sv
// Self-checking bench of the transmit pause flow control block.
`timescale 1ns/10ps
`include "tpf_cfg.svh"
module tx_pause_flow_control_tb;
  logic                clk_i = 1'b0;
  logic                sys_rst_i, reg_wr_i, reg_rd_i, rx_pause_match_i;
  logic [11:0]         reg_addr_i;
  logic [31:0]         reg_wdata_i, reg_rdata_o, v, seed;
  logic [7:0]          pause_insert_i;
  logic                frame_req_o, frame_ack_i, tx_pause_o;
  tpf_pkg::tpf_frame_t frame_kind_o;
  logic [2:0]          frame_queue_o, q, q2;
  logic [15:0]         frame_pause_time_o;
  logic [15:0]         ptime [8];
  logic [1:0]          dly_i = 2'h0;
  logic [31:0]         rdata_b, vb;
  logic                req_b, pause_b;
  int                  fail_count = 0;
  int                  cmp_count  = 0;
  int                  cyc        = 0;
  int                  gap;

  tpf_tx_pause_flow_control dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pause_insert_i(pause_insert_i),
    .rx_pause_match_i(rx_pause_match_i), .frame_req_o(frame_req_o),
    .frame_kind_o(frame_kind_o), .frame_queue_o(frame_queue_o),
    .frame_pause_time_o(frame_pause_time_o), .frame_ack_i(frame_ack_i),
    .tx_pause_o(tx_pause_o));
  tpf_link_partner partner_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .frame_req_i(frame_req_o),
    .dly_i(dly_i), .frame_ack_o(frame_ack_i));
  // A standard flow control build on the same bus reaches the response enable.
  tpf_tx_pause_flow_control #(.PFC_MODE(1'b0), .IS_100G(1'b1)) dut_std_u (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata_b),
    .pause_insert_i(pause_insert_i), .rx_pause_match_i(rx_pause_match_i),
    .frame_req_o(req_b), .frame_kind_o(), .frame_queue_o(), .frame_pause_time_o(),
    .frame_ack_i(req_b), .tx_pause_o(pause_b));

  always #12.5 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int hold_cycles(input int quanta);
    hold_cycles = quanta * `TPF_CYC_PER_QUANTUM;
  endfunction : hold_cycles

  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t out got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    vb = rdata_b;
  endtask : rd

  // Frames are sampled on the falling edge, clear of the design's own updates.
  task automatic get_frm(input logic [1:0] k, input logic [2:0] fq, input logic [15:0] t);
    int n;
    n = 0;
    while (!(frame_req_o === 1'b1 && frame_ack_i === 1'b1) && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk_out({11'h0, frame_kind_o, frame_queue_o, frame_pause_time_o}, {11'h0, k, fq, t});
    @(negedge clk_i);
  endtask : get_frm

  // The partner's answer time is reloaded from seed[1:0] after every frame.
  always @(posedge clk_i) begin
    if (frame_ack_i) begin
      dly_i <= seed[1:0];
    end
  end

  // About 230 cycles are needed; the ceiling leaves ample margin.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    sys_rst_i        = 1'b1;
    reg_wr_i         = 1'b0;
    reg_rd_i         = 1'b0;
    reg_addr_i       = 12'h000;
    reg_wdata_i      = 32'h0;
    pause_insert_i   = 8'h00;
    rx_pause_match_i = 1'b0;
    seed             = 32'h00015CE3;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`TPF_IDX_HOLDOFF, v);
    chk_reg(v, 32'h0000FFFF);
    rd(`TPF_IDX_PAUSE_TIME, v);
    chk_reg(v, 32'h0000FFFF);
    rd(`TPF_IDX_RESP_QSEL, v);
    chk_reg(v, 32'h00000000);
    rd(12'h7FF, v);
    chk_reg(v, 32'h00000000);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ptime[i] = (i == 7) ? 16'h0000 : seed[15:0];
      wr(`TPF_IDX_RESP_QSEL, i);
      wr(`TPF_IDX_HOLDOFF, 4 * (i + 1));
      wr(`TPF_IDX_PAUSE_TIME, {16'h0, ptime[i]});
    end
    for (int i = 7; i >= 0; i--) begin
      wr(`TPF_IDX_RESP_QSEL, i);
      rd(`TPF_IDX_HOLDOFF, v);
      chk_reg(v, 4 * (i + 1));
      rd(`TPF_IDX_PAUSE_TIME, v);
      chk_reg(v, {16'h0, ptime[i]});
    end
    $display("test queue tables done");
    seed = lfsr(seed);
    q = seed[2:0];
    wr(`TPF_IDX_PAUSE_REQ, 32'h1 << q);
    get_frm(tpf_pkg::TPF_FRAME_XOFF, q, ptime[q]);
    gap = 0;
    while (frame_req_o !== 1'b1 && gap < 400) begin
      @(negedge clk_i);
      gap++;
    end
    v = hold_cycles(4 * (q + 1));
    chk_out({31'h0, gap >= v - 1 && gap <= v + 6}, 32'h1);
    get_frm(tpf_pkg::TPF_FRAME_XOFF, q, ptime[q]);
    wr(`TPF_IDX_PAUSE_REQ, 32'h0);
    get_frm(tpf_pkg::TPF_FRAME_XON, q, 16'h0000);
    $display("test register request done");
    q2 = q ^ 3'h5;
    wr(`TPF_IDX_RESP_QSEL, q2);
    wr(`TPF_IDX_HOLDOFF, 32'h0000FFFF);
    @(posedge clk_i);
    pause_insert_i <= 8'h01 << q2;
    get_frm(tpf_pkg::TPF_FRAME_XOFF, q2, ptime[q2]);
    @(posedge clk_i);
    pause_insert_i <= 8'h00;
    get_frm(tpf_pkg::TPF_FRAME_XON, q2, 16'h0000);
    $display("test client request done");
    wr(`TPF_IDX_RX_PAUSE_EN, 32'h1);
    wr(`TPF_IDX_RESP_QSEL, 32'h1);
    rd(`TPF_IDX_RESP_QSEL, v);
    chk_reg(v, 32'h00000001);
    chk_reg(vb, 32'h00000001);
    @(posedge clk_i);
    rx_pause_match_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk_out({31'h0, tx_pause_o}, 32'h0);
    chk_out({31'h0, pause_b}, 32'h1);
    wr(`TPF_IDX_RESP_QSEL, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk_out({31'h0, pause_b}, 32'h0);
    wr(`TPF_IDX_RESP_QSEL, 32'h1);
    wr(`TPF_IDX_RX_PAUSE_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk_out({31'h0, pause_b}, 32'h0);
    $display("test pause response done");
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`TPF_IDX_RESP_QSEL, v);
    chk_reg(v, 32'h00000000);
    chk_reg(vb, 32'h00000000);
    rd(`TPF_IDX_PAUSE_TIME, v);
    chk_reg(v, 32'h0000FFFF);
    $display("test mid-run reset done");
    conclude();
  end
endmodule : tx_pause_flow_control_tb

// ===== verilog/tpf_cfg.svh
// Register offsets, reset values and timing constants of the transmit pause flow control block.
`ifndef TPF_CFG_SVH
`define TPF_CFG_SVH
`define TPF_IDX_HOLDOFF      12'h608
`define TPF_IDX_PAUSE_TIME   12'h609
`define TPF_IDX_RESP_QSEL    12'h60A
`define TPF_IDX_PAUSE_EN     12'h605
`define TPF_IDX_PAUSE_REQ    12'h606
`define TPF_IDX_HOLDOFF_EN   12'h607
`define TPF_IDX_RX_PAUSE_EN  12'h610
`define TPF_IDX_STATUS       12'h611
`define TPF_HOLDOFF_RST      16'hFFFF
`define TPF_PAUSE_TIME_RST   16'hFFFF
`define TPF_QUANTUM_BITS     512
`define TPF_DATAPATH_BITS    256
`define TPF_CYC_PER_QUANTUM  (`TPF_QUANTUM_BITS / `TPF_DATAPATH_BITS)
`define TPF_RESP_EN_BIT      0
`endif

// ===== verilog/tpf_pkg.sv
// Types of the transmit pause flow control block.
package tpf_pkg;
  typedef enum logic [2:0] {
    TPF_IDLE = 3'b001,
    TPF_SEND = 3'b010,
    TPF_WAIT = 3'b100
  } tpf_qstate_t;
  typedef enum logic [1:0] {
    TPF_FRAME_XON  = 2'b01,
    TPF_FRAME_XOFF = 2'b10
  } tpf_frame_t;
endpackage : tpf_pkg

// ===== verilog/tpf_tx_pause_flow_control.sv
// Transmit pause flow control: configuration tables, XOFF/XON scheduling and, in standard (non-PFC) builds, pause response.
`timescale 1ns/10ps
`include "tpf_cfg.svh"

module tpf_tx_pause_flow_control #(
  parameter int          NUM_QUEUES = 8,
  parameter bit          PFC_MODE   = 1'b1,
  parameter bit          IS_100G    = 1'b0,
  parameter int unsigned CYC_PER_Q  = `TPF_CYC_PER_QUANTUM
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [11:0]           reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  input  wire logic [NUM_QUEUES-1:0] pause_insert_i,
  input  wire logic                  rx_pause_match_i,
  output logic                       frame_req_o,
  output tpf_pkg::tpf_frame_t        frame_kind_o,
  output logic      [2:0]            frame_queue_o,
  output logic      [15:0]           frame_pause_time_o,
  input  wire logic                  frame_ack_i,
  output logic                       tx_pause_o
);
  localparam int NQ = NUM_QUEUES;

  logic [15:0]   holdoff_tbl_q [NQ];
  logic [15:0]   pause_tbl_q   [NQ];
  logic [NQ-1:0] pause_en_q;
  logic [NQ-1:0] pause_req_q;
  logic [NQ-1:0] holdoff_en_q;
  logic          resp_en_q;
  logic          rx_pause_en_q;
  logic [2:0]    qsel_q;
  logic [NQ-1:0] ins_s1_q;
  logic [NQ-1:0] ins_s2_q;
  logic          rxm_s1_q;
  logic          rxm_s2_q;
  logic [NQ-1:0] req_prev_q;
  logic [NQ-1:0] xon_pend_q;
  logic [NQ-1:0] xoff_pend_q;
  logic [15:0]   hold_cnt_q [NQ];
  logic [7:0]    qdiv_q;
  logic          quantum_tick;
  logic [NQ-1:0] req_now;
  logic          busy_q;
  logic [2:0]    grant;
  logic          grant_v;
  logic          grant_xon;
  tpf_pkg::tpf_qstate_t st_q [NQ];

  wire wr_hit = reg_wr_i;
  wire [2:0] qidx = PFC_MODE ? qsel_q : 3'h0;

  // Registers written by software.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NQ; i++) begin
        holdoff_tbl_q[i] <= `TPF_HOLDOFF_RST;
        pause_tbl_q[i]   <= `TPF_PAUSE_TIME_RST;
      end
      pause_en_q    <= '1;
      pause_req_q   <= '0;
      holdoff_en_q  <= '1;
      resp_en_q     <= 1'b0;
      rx_pause_en_q <= 1'b0;
      qsel_q        <= 3'h0;
    end else if (wr_hit) begin
      case (reg_addr_i)
        `TPF_IDX_HOLDOFF:     holdoff_tbl_q[qidx] <= reg_wdata_i[15:0];
        `TPF_IDX_PAUSE_TIME:  pause_tbl_q[qidx] <= reg_wdata_i[15:0];
        `TPF_IDX_PAUSE_EN:    pause_en_q <= reg_wdata_i[NQ-1:0];
        `TPF_IDX_PAUSE_REQ:   pause_req_q <= reg_wdata_i[NQ-1:0];
        `TPF_IDX_HOLDOFF_EN:  holdoff_en_q <= reg_wdata_i[NQ-1:0];
        `TPF_IDX_RX_PAUSE_EN: rx_pause_en_q <= reg_wdata_i[0];
        `TPF_IDX_RESP_QSEL: begin
          if (PFC_MODE) begin
            qsel_q <= reg_wdata_i[2:0];
          end else begin
            resp_en_q <= reg_wdata_i[`TPF_RESP_EN_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TPF_IDX_HOLDOFF:     reg_rdata_o <= {16'h0, holdoff_tbl_q[qidx]};
        `TPF_IDX_PAUSE_TIME:  reg_rdata_o <= {16'h0, pause_tbl_q[qidx]};
        `TPF_IDX_PAUSE_EN:    reg_rdata_o <= 32'(pause_en_q);
        `TPF_IDX_PAUSE_REQ:   reg_rdata_o <= 32'(pause_req_q);
        `TPF_IDX_HOLDOFF_EN:  reg_rdata_o <= 32'(holdoff_en_q);
        `TPF_IDX_RX_PAUSE_EN: reg_rdata_o <= {31'h0, rx_pause_en_q};
        `TPF_IDX_RESP_QSEL:   reg_rdata_o <= PFC_MODE ? {29'h0, qsel_q} : {31'h0, resp_en_q};
        `TPF_IDX_STATUS:      reg_rdata_o <= {15'h0, tx_pause_o, 16'(req_now)};
        default:              reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // Client inputs come from outside this clock, so they pass two flip-flops.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ins_s1_q <= '0;
      ins_s2_q <= '0;
      rxm_s1_q <= 1'b0;
      rxm_s2_q <= 1'b0;
    end else begin
      ins_s1_q <= pause_insert_i;
      ins_s2_q <= ins_s1_q;
      rxm_s1_q <= rx_pause_match_i;
      rxm_s2_q <= rxm_s1_q;
    end
  end

  assign req_now = pause_req_q | ins_s2_q;

  // Quantum divider; the 100 Gb variant counts one quantum per cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      qdiv_q <= 8'h0;
    end else if (IS_100G || qdiv_q == 8'(CYC_PER_Q - 1)) begin
      qdiv_q <= 8'h0;
    end else begin
      qdiv_q <= qdiv_q + 8'h1;
    end
  end
  assign quantum_tick = IS_100G ? 1'b1 : (qdiv_q == 8'(CYC_PER_Q - 1));

  // Fixed priority arbiter: lowest queue first, XON before XOFF within a queue.
  always_comb begin
    grant     = 3'h0;
    grant_v   = 1'b0;
    grant_xon = 1'b0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (xon_pend_q[i] || xoff_pend_q[i]) begin
        grant     = 3'(i);
        grant_v   = 1'b1;
        grant_xon = xon_pend_q[i];
      end
    end
  end

  // Per-queue sequencing of XOFF, hold-off and XON.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NQ; i++) begin
        st_q[i]       <= tpf_pkg::TPF_IDLE;
        hold_cnt_q[i] <= 16'h0;
      end
      req_prev_q  <= '0;
      xon_pend_q  <= '0;
      xoff_pend_q <= '0;
    end else begin
      req_prev_q <= req_now;
      for (int i = 0; i < NQ; i++) begin
        if (req_prev_q[i] && !req_now[i] && pause_en_q[i]) begin
          xon_pend_q[i] <= 1'b1;
        end else if (frame_ack_i && busy_q && frame_queue_o == 3'(i) &&
                     frame_kind_o == tpf_pkg::TPF_FRAME_XON) begin
          xon_pend_q[i] <= 1'b0;
        end
        if (!req_now[i] || !pause_en_q[i]) begin
          st_q[i]        <= tpf_pkg::TPF_IDLE;
          xoff_pend_q[i] <= 1'b0;
          hold_cnt_q[i]  <= 16'h0;
        end else begin
          case (st_q[i])
            tpf_pkg::TPF_IDLE: begin
              st_q[i]        <= tpf_pkg::TPF_SEND;
              xoff_pend_q[i] <= 1'b1;
            end
            tpf_pkg::TPF_SEND: begin
              if (frame_ack_i && busy_q && frame_queue_o == 3'(i) &&
                  frame_kind_o == tpf_pkg::TPF_FRAME_XOFF) begin
                xoff_pend_q[i] <= 1'b0;
                hold_cnt_q[i]  <= holdoff_tbl_q[i];
                st_q[i]        <= tpf_pkg::TPF_WAIT;
              end
            end
            tpf_pkg::TPF_WAIT: begin
              if (holdoff_en_q[i]) begin
                if (hold_cnt_q[i] == 16'h0) begin
                  st_q[i]        <= tpf_pkg::TPF_SEND;
                  xoff_pend_q[i] <= 1'b1;
                end else if (quantum_tick) begin
                  hold_cnt_q[i] <= hold_cnt_q[i] - 16'h1;
                end
              end
            end
            default: st_q[i] <= tpf_pkg::TPF_IDLE;
          endcase
        end
      end
    end
  end

  // Frame request toward the transmit datapath; held until acknowledged.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_q             <= 1'b0;
      frame_req_o        <= 1'b0;
      frame_kind_o       <= tpf_pkg::TPF_FRAME_XOFF;
      frame_queue_o      <= 3'h0;
      frame_pause_time_o <= 16'h0;
    end else if (busy_q) begin
      if (frame_ack_i) begin
        busy_q      <= 1'b0;
        frame_req_o <= 1'b0;
      end
    end else if (grant_v) begin
      busy_q        <= 1'b1;
      frame_req_o   <= 1'b1;
      frame_queue_o <= grant;
      frame_kind_o  <= grant_xon ? tpf_pkg::TPF_FRAME_XON : tpf_pkg::TPF_FRAME_XOFF;
      frame_pause_time_o <= grant_xon ? 16'h0 : pause_tbl_q[grant];
    end
  end

  // Pause response: gated by receive processing and the response enable.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_pause_o <= 1'b0;
    end else begin
      tx_pause_o <= rxm_s2_q && rx_pause_en_q && resp_en_q;
    end
  end

  ack_ends_req_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (busy_q && frame_ack_i) |=> !frame_req_o)
    else $error("Frame request did not drop after acknowledge.");
  xoff_time_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frame_req_o && frame_kind_o == tpf_pkg::TPF_FRAME_XOFF |->
    frame_pause_time_o == pause_tbl_q[frame_queue_o])
    else $error("XOFF pause time does not match table.");
  resp_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !resp_en_q |=> !tx_pause_o)
    else $error("Pause response while disabled.");
  rx_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rx_pause_en_q |=> !tx_pause_o)
    else $error("Pause response while receive processing off.");
  resp_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rxm_s2_q && rx_pause_en_q && resp_en_q) |=> tx_pause_o)
    else $error("Pause notification not honoured.");
  cancel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !req_now[0] |=> st_q[0] == tpf_pkg::TPF_IDLE)
    else $error("Hold-off not cancelled on request drop.");
  xon_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (req_prev_q[0] && !req_now[0] && pause_en_q[0]) |=> xon_pend_q[0])
    else $error("XON not scheduled on request drop.");
  qsel_rst_a: assert property (@(posedge clk_i)
    $past(sys_rst_i) |-> qsel_q == 3'h0 && resp_en_q == 1'b0)
    else $error("Index or response enable not reset.");
  holdoff_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q[0] == tpf_pkg::TPF_WAIT && hold_cnt_q[0] != 16'h0 && req_now[0]) |=>
    st_q[0] != tpf_pkg::TPF_SEND)
    else $error("XOFF resent before hold-off expired.");

  xoff_sent_c: cover property (@(posedge clk_i)
    frame_req_o && frame_ack_i && frame_kind_o == tpf_pkg::TPF_FRAME_XOFF);
  xon_sent_c: cover property (@(posedge clk_i)
    frame_req_o && frame_ack_i && frame_kind_o == tpf_pkg::TPF_FRAME_XON);
  resend_c: cover property (@(posedge clk_i)
    st_q[0] == tpf_pkg::TPF_WAIT ##1 st_q[0] == tpf_pkg::TPF_SEND);
  paused_c: cover property (@(posedge clk_i) tx_pause_o);
endmodule : tpf_tx_pause_flow_control
